/* File: hw/qdl_core.sv */
/*
  qdl_core: digital control of a quad voltage-output converter, serial load side.
  Assumes a host drives frame_n_i, sclk_i, sdin_i; sclk_i clocks the link domain
  and may stop between frames. Pins clear_all_n_i, load_outputs_n_i,
  power_off_n_i, chain_enable_i are asynchronous and synchronised to clock_i.
*/
`timescale 1ns/1ns
// Function
// RULE_01 - clear low forces all input and output registers to zero; code leaves buf_reg and ref_buffered_o unchanged on clear
// RULE_02 - load low copies every input register into its output register
// RULE_03 - load held low passes each new input value straight through
// RULE_04 - buffer-select bit of each word sets that channel's reference buffering
// RULE_05 - serial output driven only while chain enable is high
// RULE_06 - power-off low powers down channels and floats outputs
// RULE_07 - shift register is exactly sixteen bits
// RULE_08 - serial data sampled on falling serial clock edges
// RULE_09 - frame falling wakes input buffers and enables shifting
// RULE_10 - sixteen falling edges per frame, one bit each
// RULE_11 - frame rising before sixteenth edge discards the word
// RULE_12 - serial output changes on rising edges, valid on falling
// RULE_13 - serial output presents shift register bits unchanged
// RULE_14 - input buffers powered down after each write until next frame
// RULE_15 - host keeps serial clock at most thirty megahertz
// RULE_16 - output codes are straight unsigned binary
// RULE_17 - complete word latched into addressed channel's input register
// RULE_18 - field positions of the word are named constants
module qdl_core
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic frame_n_i,
  input wire logic sdin_i,
  input wire logic clear_all_n_i,
  input wire logic load_outputs_n_i,
  input wire logic power_off_n_i,
  input wire logic chain_enable_i,
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  output logic [11:0] code_a_o,
  output logic [11:0] code_b_o,
  output logic [11:0] code_c_o,
  output logic [11:0] code_d_o,
  output logic [3:0] ref_buffered_o,
  output logic [3:0] chan_power_down_o,
  output logic [3:0] out_hiz_o,
  output logic input_buf_on_o
);
  // link domain
  logic [15:0] shift;
  logic [4:0] bit_cnt;
  logic [15:0] word_hold;
  logic word_tgl;
  logic sdo_q;
  // system domain
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic frame_s;
  logic clr_s;
  logic load_s;
  logic pwr_s;
  logic chain_s;
  logic word_evt;
  logic [11:0] in_reg [0:3];
  logic [11:0] out_reg [0:3];
  logic [3:0] buf_reg;

  function automatic logic [1:0] word_addr(input logic [15:0] w);
    word_addr = w[qdl_pkg::ADDR_MSB:qdl_pkg::ADDR_LSB]; // [RULE_18]
  endfunction

  function automatic logic [11:0] word_code(input logic [15:0] w);
    word_code = w[qdl_pkg::CODE_MSB:qdl_pkg::CODE_LSB]; // [RULE_16] [RULE_18]
  endfunction

  // bit counter runs only inside a frame; frame high resets it, so a short frame is dropped
  // system reset also clears it, else the counter stays unknown until the first frame ends
  always_ff @(negedge sclk_i or posedge frame_n_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bit_cnt <= qdl_pkg::BIT_COUNT_ZERO;
    else if (frame_n_i)
      bit_cnt <= qdl_pkg::BIT_COUNT_ZERO; // [RULE_11] [RULE_09]
    else if (bit_cnt != qdl_pkg::BIT_COUNT_FULL)
      bit_cnt <= bit_cnt + 5'h01; // [RULE_10]
  end

  // shift register samples data on falling edges while counting
  always_ff @(negedge sclk_i)
  begin
    if (!frame_n_i && bit_cnt != qdl_pkg::BIT_COUNT_FULL)
      shift <= {shift[14:0], sdin_i}; // [RULE_07] [RULE_08] [RULE_10]
  end

  // word handed over with a toggle at the sixteenth edge; holding stays stable until next word
  // toggle is reset together with its synchroniser so no false word follows reset
  always_ff @(negedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      word_tgl <= 1'b0;
    else if (!frame_n_i && bit_cnt == (qdl_pkg::BIT_COUNT_FULL - 5'h01))
    begin
      word_hold <= {shift[14:0], sdin_i}; // [RULE_17]
      word_tgl <= ~word_tgl;
    end
  end

  // daisy output moves on rising edges so it is settled at the next falling edge
  always_ff @(posedge sclk_i)
  begin
    sdo_q <= shift[qdl_pkg::WORD_BITS-1]; // [RULE_12] [RULE_13]
  end

  // word toggle crosses into clock_i; only the second and third stages are compared
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end
    else
    begin
      tgl_s1 <= word_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end
  assign word_evt = tgl_s2 ^ tgl_s3;

  qdl_sync u_frame (.clk_i(clock_i), .rst_n_i(rst_n_i), .d_i(~frame_n_i), .q_o(frame_s));
  qdl_sync u_clr (.clk_i(clock_i), .rst_n_i(rst_n_i), .d_i(clear_all_n_i), .q_o(clr_s));
  qdl_sync u_load (.clk_i(clock_i), .rst_n_i(rst_n_i), .d_i(load_outputs_n_i), .q_o(load_s));
  qdl_sync u_pwr (.clk_i(clock_i), .rst_n_i(rst_n_i), .d_i(power_off_n_i), .q_o(pwr_s));
  qdl_sync u_chain (.clk_i(clock_i), .rst_n_i(rst_n_i), .d_i(chain_enable_i), .q_o(chain_s));

  // input registers; clear wins over a word arriving together with it
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !clr_s)
    begin
      for (int i = 0; i < qdl_pkg::CHANNELS; i++)
        in_reg[i] <= qdl_pkg::CODE_ZERO; // [RULE_01]
    end
    else if (word_evt)
      in_reg[word_addr(word_hold)] <= word_code(word_hold); // [RULE_17]
  end

  // reference buffer choice per channel from its own word
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      buf_reg <= 4'h0;
    else if (word_evt)
      buf_reg[word_addr(word_hold)] <= word_hold[qdl_pkg::BUF_POS]; // [RULE_04]
  end

  // output registers follow input registers while load is low, one cycle behind
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !clr_s)
    begin
      for (int i = 0; i < qdl_pkg::CHANNELS; i++)
        out_reg[i] <= qdl_pkg::CODE_ZERO; // [RULE_01]
    end
    else if (!load_s)
    begin
      for (int i = 0; i < qdl_pkg::CHANNELS; i++)
        out_reg[i] <= in_reg[i]; // [RULE_02] [RULE_03]
    end
  end

  // outputs registered; power-off takes channels down and floats outputs
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      code_a_o <= qdl_pkg::CODE_ZERO;
      code_b_o <= qdl_pkg::CODE_ZERO;
      code_c_o <= qdl_pkg::CODE_ZERO;
      code_d_o <= qdl_pkg::CODE_ZERO;
      ref_buffered_o <= 4'h0;
      chan_power_down_o <= 4'h0;
      out_hiz_o <= 4'h0;
      input_buf_on_o <= 1'b0;
    end
    else
    begin
      code_a_o <= out_reg[0];
      code_b_o <= out_reg[1];
      code_c_o <= out_reg[2];
      code_d_o <= out_reg[3];
      ref_buffered_o <= buf_reg; // [RULE_04]
      chan_power_down_o <= {4{~pwr_s}}; // [RULE_06]
      out_hiz_o <= {4{~pwr_s}}; // [RULE_06]
      input_buf_on_o <= frame_s; // [RULE_09] [RULE_14]
    end
  end

  // serial output: data from link domain, enable from system domain
  // limitation: data is a link-domain flop, passed through a system flop, so it trails by a few ns
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      serial_out_o <= 1'b0;
      serial_out_oe_n_o <= 1'b1;
    end
    else
    begin
      serial_out_o <= sdo_q; // [RULE_13]
      serial_out_oe_n_o <= ~chain_s; // [RULE_05]
    end
  end

  // assertions
  a_clear_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !clr_s |=> (out_reg[0] == qdl_pkg::CODE_ZERO && in_reg[3] == qdl_pkg::CODE_ZERO)) // [RULE_01]
    else $error("clear did not zero registers");
  a_load_copy: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clr_s && !load_s) |=> out_reg[1] == $past(in_reg[1])) // [RULE_02]
    else $error("load did not copy input register");
  a_load_through: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clr_s && !load_s && word_evt) ##1 (clr_s && !load_s) [*2] |-> out_reg[word_addr(word_hold)]
      == word_code(word_hold)) // [RULE_03]
    else $error("held load did not pass word through");
  a_load_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clr_s && load_s) |=> $stable(out_reg[2])) // [RULE_02]
    else $error("output changed while load high");
  a_word_latch: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (word_evt && clr_s) |=> in_reg[word_addr(word_hold)] == word_code(word_hold)) // [RULE_17]
    else $error("word not latched into addressed channel");
  a_buf_select: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    word_evt |-> ##2 ref_buffered_o[word_addr(word_hold)] == word_hold[qdl_pkg::BUF_POS]) // [RULE_04]
    else $error("buffer select not applied");
  a_power_down: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !pwr_s |=> (out_hiz_o == 4'hf && chan_power_down_o == 4'hf)) // [RULE_06]
    else $error("power-off did not float outputs");
  a_chain_oe: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !chain_s |=> serial_out_oe_n_o) // [RULE_05]
    else $error("serial output driven while chain disabled");
  a_bit_count: assert property (@(negedge sclk_i)
    !frame_n_i |-> bit_cnt <= qdl_pkg::BIT_COUNT_FULL) // [RULE_10]
    else $error("bit counter overran");
  a_buf_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !frame_s |=> !input_buf_on_o) // [RULE_14]
    else $error("input buffers on outside frame");

  c_word: cover property (@(posedge clock_i) disable iff (!rst_n_i) word_evt);
  c_through: cover property (@(posedge clock_i) disable iff (!rst_n_i) word_evt && !load_s);
  c_clear: cover property (@(posedge clock_i) disable iff (!rst_n_i) !clr_s && word_evt);
  c_chain: cover property (@(posedge clock_i) disable iff (!rst_n_i) chain_s && frame_s);
endmodule // qdl_core

/* File: hw/qdl_pkg.sv */
/*
  qdl_pkg: constants for the quad converter serial load block.
  Assumes nothing of its surroundings; every use is written qdl_pkg::name.
*/
package qdl_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int CHANNELS = 4;
  localparam int ADDR_BITS = 2;
  localparam int CNT_BITS = 5;
  // word field layout, kept here so that it can be changed in one place
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 14;
  localparam int BUF_POS = 13;
  localparam int CODE_MSB = 11;
  localparam int CODE_LSB = 0;
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
  localparam logic [4:0] BIT_COUNT_ZERO = 5'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam int SCLK_MAX_MHZ = 30;
endpackage

/* File: hw/qdl_sync.sv */
/*
  qdl_sync: two flip-flop level synchroniser.
  Assumes the input is asynchronous to clk_i.
*/
`timescale 1ns/1ns
module qdl_sync
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta;

  // first stage is read only by the second
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // qdl_sync

/* File: tb/qdl_host_model.sv */
/*
  qdl_host_model: host serial port that writes words into the block.
  Assumes the bench calls send(); the serial clock stands high between frames.
*/
`timescale 1ns/1ns
module qdl_host_model
(
  output logic sclk_o,
  output logic frame_n_o,
  output logic sdin_o
);
  // idle: clock parked high, frame released
  initial
  begin
    sclk_o = 1'b1;
    frame_n_o = 1'b1;
    sdin_o = 1'b0;
  end
  // n bits msb first; fewer than 16 then frame rising makes an abort
  task automatic send(input logic [15:0] word, input int n);
    #3;
    frame_n_o = 1'b0;
    for (int i = 15; i > 15 - n; i--)
    begin
      sdin_o = word[i]; // set at rise, steady over the fall
      #62;
      sclk_o = 1'b0; // 125 ns period, below 30 MHz
      #63;
      sclk_o = 1'b1;
    end
    #62;
    frame_n_o = 1'b1;
    sdin_o = ~sdin_o; // no stale bit is left on the line
    #125;
  endtask
endmodule // qdl_host_model

/* File: tb/tb_quad_dac_serial_load.sv */
/*
  tb_quad_dac_serial_load: self-checking bench for qdl_core.
  Assumes qdl_host_model drives the link; pins are driven here.
*/
`timescale 1ns/1ns
module tb_quad_dac_serial_load;
  typedef struct {logic [15:0] w; logic [1:0] ch; logic [11:0] code; logic [3:0] bufs;} qdl_row_t;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b1;
  logic clear_all_n_i = 1'b1;
  logic load_outputs_n_i = 1'b0;
  logic power_off_n_i = 1'b1;
  logic chain_enable_i = 1'b0;
  wire logic sclk, frame_n, sdin, serial_out, oe_n, buf_on;
  wire logic [3:0][11:0] codes;
  wire logic [3:0] ref_buf, pwr_dn, hiz;
  int n_mismatch = 0;
  int tests_run = 0;
  // word, channel, code and buffer bits expected after it
  qdl_row_t rows [4] = '{'{16'h0abc, 2'h0, 12'habc, 4'h0}, '{16'h6123, 2'h1, 12'h123, 4'h2},
    '{16'ha456, 2'h2, 12'h456, 4'h6}, '{16'hcfff, 2'h3, 12'hfff, 4'h6}};
  always #2 clock_i = ~clock_i;
  qdl_host_model u_host (.sclk_o(sclk), .frame_n_o(frame_n), .sdin_o(sdin));
  qdl_core u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .frame_n_i(frame_n),
    .sdin_i(sdin), .clear_all_n_i(clear_all_n_i), .load_outputs_n_i(load_outputs_n_i),
    .power_off_n_i(power_off_n_i), .chain_enable_i(chain_enable_i), .serial_out_o(serial_out),
    .serial_out_oe_n_o(oe_n), .code_a_o(codes[0]), .code_b_o(codes[1]), .code_c_o(codes[2]),
    .code_d_o(codes[3]), .ref_buffered_o(ref_buf), .chan_power_down_o(pwr_dn), .out_hiz_o(hiz),
    .input_buf_on_o(buf_on));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog: whole run is some 22 us
  initial
  begin
    #100000;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    rst_n_i <= 1'b0;
    wt(16);
    chk(codes[0], 12'h000);
    chk(oe_n, 1'b1);
    rst_n_i <= 1'b1;
    wt(5);
    // load held low: every word goes straight to its output
    foreach (rows[i])
    begin
      u_host.send(rows[i].w, 16);
      wt(10);
      chk(codes[rows[i].ch], rows[i].code);
      chk(ref_buf, rows[i].bufs);
      chk(buf_on, 1'b0);
    end
    $display("test rows done");
    // load high holds outputs until a low pulse
    load_outputs_n_i <= 1'b1;
    u_host.send(16'h0555, 16);
    wt(10);
    chk(codes[0], 12'habc);
    load_outputs_n_i <= 1'b0;
    wt(3);
    load_outputs_n_i <= 1'b1;
    wt(8);
    chk(codes[0], 12'h555);
    chk(codes[1], 12'h123);
    load_outputs_n_i <= 1'b0;
    $display("test load done");
    // aborted frame changes nothing, next full frame lands
    u_host.send(16'h4777, 8);
    wt(10);
    chk(codes[1], 12'h123);
    u_host.send(16'h4321, 16);
    wt(10);
    chk(codes[1], 12'h321);
    $display("test abort done");
    // chain output enable and shifted bit
    chain_enable_i <= 1'b1;
    wt(5);
    chk(oe_n, 1'b0);
    u_host.send(16'h8001, 16);
    wt(10);
    chk(serial_out, 1'b1);
    chain_enable_i <= 1'b0;
    wt(5);
    chk(oe_n, 1'b1);
    $display("test chain done");
    // power off floats all outputs
    power_off_n_i <= 1'b0;
    wt(5);
    chk(pwr_dn, 4'hf);
    chk(hiz, 4'hf);
    power_off_n_i <= 1'b1;
    wt(5);
    chk(pwr_dn | hiz, 4'h0);
    $display("test power done");
    // clear zeroes code outputs and input registers alike (not ref_buf), load low shows inputs
    clear_all_n_i <= 1'b0;
    wt(5);
    clear_all_n_i <= 1'b1;
    wt(8);
    for (int i = 0; i < 4; i++)
      chk(codes[i], 12'h000);
    $display("test clear done");
    // reset in mid-run clears outputs; the link still works afterwards
    u_host.send(16'h0abc, 16);
    wt(10);
    chk(codes[0], 12'habc);
    rst_n_i <= 1'b0;
    wt(4);
    chk(codes[0], 12'h000);
    chk(ref_buf, 4'h0);
    chk(oe_n, 1'b1);
    rst_n_i <= 1'b1;
    wt(5);
    u_host.send(16'h2abc, 16);
    wt(10);
    chk(codes[0], 12'habc);
    chk(ref_buf, 4'h1);
    $display("test reset done");
    stop_test();
  end
endmodule // tb_quad_dac_serial_load
